// ### hdl/buf_if.sv
// link between the controller and its page data buffer
`timescale 1ns/100ps
interface buf_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface

// ### hdl/byte_buffer.sv
// page data buffer, registered read port
`timescale 1ns/100ps
module byte_buffer (
    input wire logic pclk,
    buf_if.mem bus
);
    import nand_host_pkg::*;
    logic [7:0] mem_r [0:(1 << BUF_AW) - 1];
    // no reset on the array keeps it a plain ram
    always_ff @(posedge pclk) begin
        if (bus.wr_en) begin
            mem_r[bus.wr_addr] <= bus.wr_data;
        end
        bus.rd_data <= mem_r[bus.rd_addr];
    end
endmodule

// ### hdl/nand_dual_plane_host.sv
// apb-driven host controller for dual-plane nand program/erase/features
`timescale 1ns/100ps
module nand_dual_plane_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic re_n,
    output logic wp_n,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in,
    input wire logic rb_n
);
    import nand_host_pkg::*;

    // row address of the current request, by number of address cycles
    function automatic logic [ROW_W-1:0] row_of(logic [39:0] a,
                                                logic [2:0] n);
        if (n == 3'h3) begin
            row_of = a[ROW_W-1:0];
        end else begin
            row_of = a[39:16];
        end
    endfunction

    buf_if bif ();
    byte_buffer u_buf (
        .pclk(pclk),
        .bus(bif)
    );

    logic [CTRL_W-1:0] ctrl_r;
    logic [15:0] cmds_r;
    logic [39:0] addr_r;
    logic [CNT_W-1:0] count_r;
    logic [BUF_AW-1:0] wptr_r;
    logic [7:0] p1_r;
    logic [31:0] rx_r;
    logic [ERR_W-1:0] err_r;
    logic [ERR_W-1:0] err_set;
    logic scr_on_r;
    logic defpgm_r;
    pend_t pend_r;
    logic [ROW_W-1:0] pend_row_r;
    logic [ROW_W-1:0] last_row_r;
    logic last_row_v_r;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [1:0] ph_r;
    logic [CNT_W-1:0] idx_r;
    logic [5:0] cnt_r;
    logic [5:0] lim_r;
    logic post_r;

    // apb decode
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CMDS) ||
                    (paddr == OFS_ADDR_LO) || (paddr == OFS_ADDR_HI) ||
                    (paddr == OFS_COUNT) || (paddr == OFS_DATA) ||
                    (paddr == OFS_RX) || (paddr == OFS_STATUS);
    assign pready = 1'b1; // every access completes in its first access cycle
    assign pslverr = psel && penable && !mapped;

    // request checks, done on the start write itself
    logic [7:0] c1;
    logic [7:0] c2;
    logic c1en;
    logic c2en;
    logic [2:0] naddr;
    logic [ROW_W-1:0] row;
    logic start_w;
    logic final_w;
    logic first_w;
    logic go_w;
    assign c1 = cmds_r[7:0];
    assign c2 = cmds_r[15:8];
    assign c1en = pwdata[CB_CMD1_EN];
    assign c2en = pwdata[CB_CMD2_EN];
    assign naddr = pwdata[CB_NADDR +: 3];
    assign row = row_of(addr_r, naddr);
    assign start_w = wr_acc && (paddr == OFS_CTRL) && pwdata[CB_START] &&
                     (state_r == S_IDLE);
    assign first_w = c2en && ((c2 == CMD_PLANE_CONF) ||
                              (c2 == CMD_ERASE_PLANE));
    assign final_w = c2en && (((pend_r == PEND_PROG) &&
                     ((c2 == CMD_PROG_CONF) || (c2 == CMD_CACHE_CONF))) ||
                     ((pend_r == PEND_ERASE) && (c2 == CMD_ERASE_CONF)));

    always_comb begin
        err_set = '0;
        if (start_w) begin
            err_set[E_MIX] = c1en && (((pend_r == PEND_PROG) &&
                (c1 == CMD_ERASE)) || ((pend_r == PEND_ERASE) &&
                (c1 == CMD_PROG)));
            err_set[E_PLANE] = final_w &&
                (row[PLANE_BIT] == pend_row_r[PLANE_BIT]);
            err_set[E_PAGE] = final_w &&
                (row[PAGE_W-1:0] != pend_row_r[PAGE_W-1:0]);
            err_set[E_SCR] = pwdata[CB_SCR_WANT] && c1en &&
                (c1 == CMD_PROG) && !scr_on_r;
            err_set[E_GUARD] = pwdata[CB_DEF_CHANGE] && c1en &&
                (c1 == CMD_SET_FEAT) && (addr_r[7:0] == FEAT_CONFIG) &&
                !defpgm_r;
            err_set[E_NOP] = scr_on_r && c1en && (c1 == CMD_PROG) &&
                last_row_v_r && (row == last_row_r);
        end
        // busy beyond its longest figure
        if ((state_r == S_BUSY) && !rb_n && (lim_r != 6'h00) &&
            (cnt_r == lim_r)) begin
            err_set[E_TIMEOUT] = 1'b1;
        end
    end
    assign go_w = start_w && (err_set[E_NOP:E_MIX] == '0);

    // software registers; a new error wins over its clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
            cmds_r <= '0;
            addr_r <= '0;
            count_r <= '0;
            err_r <= '0;
        end else begin
            if (wr_acc && (paddr == OFS_CTRL)) begin
                ctrl_r <= pwdata[CTRL_W-1:0];
            end
            if (wr_acc && (paddr == OFS_CMDS)) begin
                cmds_r <= pwdata[15:0];
            end
            if (wr_acc && (paddr == OFS_ADDR_LO)) begin
                addr_r[31:0] <= pwdata;
            end
            if (wr_acc && (paddr == OFS_ADDR_HI)) begin
                addr_r[39:32] <= pwdata[7:0];
            end
            if (wr_acc && (paddr == OFS_COUNT)) begin
                count_r <= pwdata[CNT_W-1:0];
            end
            if (wr_acc && (paddr == OFS_STATUS)) begin
                err_r <= (err_r & ~pwdata[SB_ERR +: ERR_W]) | err_set;
            end else begin
                err_r <= err_r | err_set;
            end
        end
    end

    // buffer fill pointer, rewound by a count write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_r <= '0;
            p1_r <= '0;
        end else if (wr_acc && (paddr == OFS_COUNT)) begin
            wptr_r <= '0;
        end else if (wr_acc && (paddr == OFS_DATA)) begin
            wptr_r <= wptr_r + 8'h01;
            if (wptr_r == '0) begin
                p1_r <= pwdata[7:0]; // first feature parameter
            end
        end
    end
    assign bif.wr_en = wr_acc && (paddr == OFS_DATA);
    assign bif.wr_addr = wptr_r;
    assign bif.wr_data = pwdata[7:0];
    assign bif.rd_addr = idx_r[BUF_AW-1:0];

    // read mux
    always_comb begin
        prdata = '0;
        case (paddr)
            OFS_CTRL: prdata[CTRL_W-1:0] = ctrl_r;
            OFS_CMDS: prdata[15:0] = cmds_r;
            OFS_ADDR_LO: prdata = addr_r[31:0];
            OFS_ADDR_HI: prdata[7:0] = addr_r[39:32];
            OFS_COUNT: prdata[CNT_W-1:0] = count_r;
            OFS_RX: prdata = rx_r;
            OFS_STATUS: begin
                prdata[SB_BUSY] = (state_r != S_IDLE);
                prdata[SB_SCR_ON] = scr_on_r;
                prdata[SB_DEFPGM_ON] = defpgm_r;
                prdata[SB_PEND] = (pend_r != PEND_NONE);
                prdata[SB_ERR +: ERR_W] = err_r;
            end
            default: prdata = '0;
        endcase
        if (!rd_acc) begin
            prdata = '0;
        end
    end

    // pairing and feature tracking, taken when a request is accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= PEND_NONE;
            pend_row_r <= '0;
            scr_on_r <= 1'b0;
            defpgm_r <= 1'b0;
            last_row_r <= '0;
            last_row_v_r <= 1'b0;
        end else if (go_w) begin
            if (first_w) begin
                pend_r <= (c2 == CMD_PLANE_CONF) ? PEND_PROG : PEND_ERASE;
                pend_row_r <= row;
            end else if (final_w || c2en) begin
                pend_r <= PEND_NONE;
            end
            if (c1en && (c1 == CMD_SET_FEAT)) begin
                if (addr_r[7:0] == FEAT_CONFIG) begin
                    scr_on_r <= p1_r[SCR_EN_BIT];
                end
                if (addr_r[7:0] == FEAT_DEFPGM) begin
                    defpgm_r <= p1_r[DEFPGM_BIT];
                end
            end
            if (c1en && (c1 == CMD_PROG)) begin
                last_row_r <= row;
                last_row_v_r <= 1'b1;
            end
            if (c1en && (c1 == CMD_ERASE)) begin
                last_row_v_r <= 1'b0;
            end
        end
    end

    // sequencer: byte cycles run in three phases, drive/strobe/release
    logic byte_st;
    logic [CNT_W-1:0] byte_n;
    logic last_byte;
    assign byte_st = (state_r == S_CMD1) || (state_r == S_ADDR) ||
                     (state_r == S_WDATA) || (state_r == S_RDATA) ||
                     (state_r == S_CMD2);
    always_comb begin
        case (state_r)
            S_ADDR: byte_n = {6'h00, ctrl_r[CB_NADDR +: 3]};
            S_WDATA: byte_n = count_r;
            S_RDATA: byte_n = count_r;
            default: byte_n = 9'h001;
        endcase
    end
    assign last_byte = (ph_r == 2'h2) && (idx_r == byte_n);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: if (go_w) state_nxt = S_CMD1;
            S_CMD1: begin
                if (!ctrl_r[CB_CMD1_EN] || last_byte) state_nxt = S_ADDR;
            end
            S_ADDR: begin
                if (byte_n == '0 || last_byte) begin
                    state_nxt = ctrl_r[CB_WAIT_FIRST] ? S_WB : S_GAP;
                end
            end
            S_WB: if (cnt_r == 6'(WB_CYC - 1)) state_nxt = S_BUSY;
            S_BUSY: begin
                if (rb_n) state_nxt = post_r ? S_IDLE : S_GAP;
            end
            S_GAP: begin
                if (count_r == '0) begin
                    state_nxt = S_CMD2;
                end else if (cnt_r == 6'(GAP_CYC - 1)) begin
                    state_nxt = ctrl_r[CB_READ] ? S_RDATA : S_WDATA;
                end
            end
            S_WDATA: if (last_byte) state_nxt = S_CMD2;
            S_RDATA: if (last_byte) state_nxt = S_CMD2;
            S_CMD2: begin
                if (!ctrl_r[CB_CMD2_EN] || last_byte) begin
                    state_nxt = (ctrl_r[CB_BUSY_WAIT] &&
                                 !ctrl_r[CB_WAIT_FIRST]) ? S_WB : S_IDLE;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // phase, byte index and wait counters restart on each state change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= '0;
            idx_r <= '0;
            cnt_r <= '0;
        end else if (state_nxt != state_r) begin
            ph_r <= '0;
            idx_r <= '0;
            cnt_r <= '0;
        end else begin
            if (byte_st) begin
                ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
            end
            if (byte_st && (ph_r == 2'h1)) begin
                idx_r <= idx_r + 9'h001; // prefetches the next data byte
            end
            if (!byte_st && (cnt_r != BUSY_SAT)) begin
                cnt_r <= cnt_r + 6'h01;
            end
        end
    end

    // busy limit for this request and whether busy closes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_r <= '0;
            post_r <= 1'b0;
        end else if (go_w) begin
            post_r <= !pwdata[CB_WAIT_FIRST];
            if (first_w) begin
                lim_r <= 6'(DBSY_CYC);
            end else if (c1en && ((c1 == CMD_SET_FEAT) ||
                                  (c1 == CMD_GET_FEAT))) begin
                lim_r <= 6'(FEAT_CYC);
            end else begin
                lim_r <= '0; // array busy has no limit here
            end
        end
    end

    // read capture, one cycle into the low read strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_r <= '0;
        end else if ((state_r == S_RDATA) && (ph_r == 2'h1)) begin
            rx_r[idx_r[1:0]*8 +: 8] <= io_in;
        end
    end

    // pins, registered; strobe low in phase 1, data held to phase 0
    logic wr_st;
    assign wr_st = byte_st && (state_r != S_RDATA) &&
                   !((state_r == S_CMD1) && !ctrl_r[CB_CMD1_EN]) &&
                   !((state_r == S_CMD2) && !ctrl_r[CB_CMD2_EN]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_n <= 1'b1;
            cle <= 1'b0;
            ale <= 1'b0;
            we_n <= 1'b1;
            re_n <= 1'b1;
            wp_n <= 1'b0;
            io_out <= '0;
            io_oe <= 1'b0;
        end else begin
            ce_n <= (state_r == S_IDLE);
            wp_n <= ctrl_r[CB_WP_RELEASE];
            we_n <= !(wr_st && (ph_r == 2'h0) && (idx_r != byte_n));
            re_n <= !((state_r == S_RDATA) && (ph_r == 2'h0));
            io_oe <= wr_st;
            if (wr_st && (ph_r == 2'h0)) begin
                cle <= (state_r == S_CMD1) || (state_r == S_CMD2);
                ale <= (state_r == S_ADDR);
                case (state_r)
                    S_CMD1: io_out <= c1;
                    S_CMD2: io_out <= c2;
                    S_ADDR: io_out <= addr_r[idx_r[2:0]*8 +: 8];
                    default: io_out <= bif.rd_data;
                endcase
            end else if (!byte_st) begin
                cle <= 1'b0;
                ale <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_late_busy;
        (state_r == S_BUSY) && !rb_n && (lim_r != 6'h00) &&
        (cnt_r == lim_r);
    endsequence
    sequence s_cmd_strobe;
        cle && !we_n ##1 cle && we_n;
    endsequence

    AST_MIX_REFUSED: assert property (start_w && c1en &&
        (pend_r == PEND_PROG) && (c1 == CMD_ERASE)
        |=> err_r[E_MIX] && (state_r == S_IDLE))
        else $error("mixed dual-plane request not refused");
    AST_PLANE_DIFF: assert property (start_w && final_w &&
        (row[PLANE_BIT] == pend_row_r[PLANE_BIT])
        |=> err_r[E_PLANE] && (state_r == S_IDLE) [*2])
        else $error("same-plane pair not refused");
    AST_PAGE_SAME: assert property (start_w && final_w &&
        (row[PAGE_W-1:0] != pend_row_r[PAGE_W-1:0]) |=> err_r[E_PAGE])
        else $error("page mismatch not flagged");
    AST_SCR_FIRST: assert property (start_w && pwdata[CB_SCR_WANT] &&
        c1en && (c1 == CMD_PROG) && !scr_on_r |=> state_r == S_IDLE)
        else $error("program started before scrambling on");
    AST_DEF_GUARD: assert property (start_w && err_set[E_GUARD]
        |=> ce_n && err_r[E_GUARD])
        else $error("default change ran without guard");
    AST_NOP_ONCE: assert property (start_w && err_set[E_NOP]
        |=> (state_r == S_IDLE) && $stable(last_row_r))
        else $error("scrambled page programmed twice");
    AST_READY_WAIT: assert property ((state_r == S_BUSY) && !rb_n
        |=> (state_r == S_BUSY) && !ce_n)
        else $error("left busy wait before ready");
    AST_DBSY_LIMIT: assert property (s_late_busy
        |=> err_r[E_TIMEOUT])
        else $error("overlong confirm busy not flagged");
    AST_CMD_CYCLE: assert property ($fell(we_n) && cle
        |-> s_cmd_strobe ##1 we_n)
        else $error("command strobe malformed");
endmodule

// ### hdl/nand_host_pkg.sv
// constants, register map and types of the dual-plane NAND host controller
package nand_host_pkg;
    // timing, in ns and in pclk cycles
    localparam int CLK_PERIOD_NS = 50;
    localparam int PLANE_CONFIRM_BUSY_TIME_NS = 1000;
    localparam int FEATURE_ACCESS_BUSY_TIME_NS = 1000;
    localparam int WB_TIME_NS = 100;
    localparam int WHR_TIME_NS = 80;
    localparam int DBSY_CYC = PLANE_CONFIRM_BUSY_TIME_NS / CLK_PERIOD_NS;
    localparam int FEAT_CYC = FEATURE_ACCESS_BUSY_TIME_NS / CLK_PERIOD_NS;
    localparam int WB_CYC = (WB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (WHR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PARTIAL_PROGRAM_COUNT = 1;
    // apb register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMDS = 8'h04;
    localparam logic [7:0] OFS_ADDR_LO = 8'h08;
    localparam logic [7:0] OFS_ADDR_HI = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_RX = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    // control register fields
    localparam int CB_START = 0;
    localparam int CB_CMD1_EN = 1;
    localparam int CB_CMD2_EN = 2;
    localparam int CB_BUSY_WAIT = 3;
    localparam int CB_WAIT_FIRST = 4;
    localparam int CB_READ = 5;
    localparam int CB_SCR_WANT = 6;
    localparam int CB_DEF_CHANGE = 7;
    localparam int CB_NADDR = 8;
    localparam int CB_WP_RELEASE = 11;
    localparam int CTRL_W = 12;
    // status register fields
    localparam int SB_BUSY = 0;
    localparam int SB_SCR_ON = 1;
    localparam int SB_DEFPGM_ON = 2;
    localparam int SB_PEND = 3;
    localparam int SB_ERR = 8;
    localparam int E_MIX = 0;
    localparam int E_PLANE = 1;
    localparam int E_PAGE = 2;
    localparam int E_SCR = 3;
    localparam int E_GUARD = 4;
    localparam int E_NOP = 5;
    localparam int E_TIMEOUT = 6;
    localparam int ERR_W = 7;
    // nand commands and features
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PLANE_CONF = 8'h11;
    localparam logic [7:0] CMD_CACHE_CONF = 8'h15;
    localparam logic [7:0] CMD_PROG_CONF = 8'h10;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_PLANE = 8'hD1;
    localparam logic [7:0] CMD_ERASE_CONF = 8'hD0;
    localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
    localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
    localparam logic [7:0] FEAT_CONFIG = 8'hB0;
    localparam logic [7:0] FEAT_DEFPGM = 8'hB1;
    localparam int SCR_EN_BIT = 0;
    localparam int DEFPGM_BIT = 0;
    // row address fields, same for both densities
    localparam int PLANE_BIT = 6;
    localparam int PAGE_W = 6;
    localparam int ROW_W = 24;
    localparam int BUF_AW = 8;
    localparam int CNT_W = 9;
    localparam logic [5:0] BUSY_SAT = 6'h3F;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_CMD1 = 4'h1, S_ADDR = 4'h2, S_WB = 4'h3,
        S_BUSY = 4'h4, S_GAP = 4'h5, S_WDATA = 4'h6, S_RDATA = 4'h7,
        S_CMD2 = 4'h8
    } seq_state_t;
    typedef enum logic [1:0] {
        PEND_NONE = 2'h0, PEND_PROG = 2'h1, PEND_ERASE = 2'h2
    } pend_t;
endpackage

// ### verif/nand_dev_model.sv
// behavioural nand device answering the host controller
`timescale 1ns/100ps
module nand_dev_model (
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic [7:0] io_out,
    output logic [7:0] io_in,
    output logic rb_n
);
    logic [7:0] last_cmd;
    logic [7:0] feat_r;
    int ndat;
    // volatile feature byte, default again at every power-up
    initial begin
        rb_n = 1'b1;
        last_cmd = 8'h00;
        feat_r = 8'h00;
        ndat = 0;
    end
    // released bus shows the inverse, never a stale byte
    // a status read answers ready and pass on both planes
    assign io_in = (!ce_n && !re_n) ?
                   ((last_cmd == 8'h70) ? 8'hE0 : feat_r) : ~feat_r;
    task automatic busy(input int t);
        rb_n <= #20 1'b0;
        rb_n <= #(20 + t) 1'b1;
    endtask
    // latch on strobe rise; long array busy only after final confirm
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            last_cmd = io_out;
            ndat = 0;
            if (io_out == 8'h11 || io_out == 8'hD1) busy(500);
            if (io_out == 8'h10 || io_out == 8'h15) busy(3000);
            if (io_out == 8'hD0) busy(3000);
        end else if (!ce_n && ale && last_cmd == 8'hEE) begin
            busy(800);
        end else if (!ce_n && !ale && last_cmd == 8'hEF) begin
            if (ndat == 0) feat_r = io_out;
            if (ndat == 0) busy(800);
            ndat++;
        end
    end
endmodule

// ### verif/nand_dual_plane_host_test.sv
// self-checking bench of the dual-plane nand host controller
`timescale 1ns/100ps
module nand_dual_plane_host_test;
    import nand_host_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata, s;
    logic pready, pslverr, slv, ce_n, cle, ale, we_n, re_n, rb_n;
    logic wp_n, io_oe;
    logic [7:0] p1;
    logic [7:0] io_out, io_in;
    logic [23:0] r;
    int err_count = 0, total_checks = 0;
    always #25 pclk = ~pclk;
    nand_dual_plane_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
        .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
        .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .rb_n(rb_n));
    nand_dev_model dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .io_out(io_out), .io_in(io_in), .rb_n(rb_n));
    task close_out;
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        total_checks++;
        if (seen !== ex) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", nm, ex, seen);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        s = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // start one request, wait for idle, return and clear sticky errors
    task run(input logic [7:0] c1, c2, fl, input logic [2:0] na,
             input logic [23:0] row, input logic [6:0] ex);
        int n;
        apb(1, OFS_CMDS, {16'h0000, c2, c1});
        apb(1, OFS_ADDR_LO, {8'h00, row});
        apb(1, OFS_CTRL, {20'h00000, 1'b1, na, fl[7:2], 2'b11});
        n = 0;
        do begin
            apb(0, OFS_STATUS, 32'h0);
            n++;
        end while (s[SB_BUSY] !== 1'b0 && n < 400);
        chk("idle", {31'h0, s[SB_BUSY]}, 32'h0);
        chk("err bits", {25'h0, s[14:8]}, {25'h0, ex});
        apb(1, OFS_STATUS, 32'h00007F00);
        // status after the clear, so callers see the live flags
        apb(0, OFS_STATUS, 32'h0);
        chk("err clear", {25'h0, s[14:8]}, 32'h0);
    endtask
    initial begin
        #(50 * 60000);
        err_count++;
        close_out;
    end
    initial begin
        void'($urandom(32'h7557));
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_STATUS, 32'h0);
        chk("status", s, 32'h0);
        chk("write protect", {31'h0, wp_n}, 32'h0);
        apb(0, 8'h40, 32'h0);
        chk("unmapped", {31'h0, slv}, 32'h1);
        run(8'h80, 8'h10, 8'h4C, 3, 24'h0, 7'h08);
        run(8'hEF, 8'h00, 8'h88, 1, 24'hB0, 7'h10);
        for (int i = 0; i < 4; i++) begin
            r = 24'($urandom) & 24'hFFFFBF;
            run(8'h80, 8'h11, 8'h0C, 3, r, 7'h00);
            run(8'h85, 8'h00, 8'h00, 2, r, 7'h00);
            chk("pending", {31'h0, s[SB_PEND]}, 32'h1);
            run(8'h60, 8'hD0, 8'h0C, 3, r ^ 24'h40, 7'h01);
            run(8'h80, (i[0] ? 8'h15 : 8'h10), 8'h0C, 3,
                r ^ 24'h40 ^ {8'($urandom), 16'h0}, 7'h00);
            chk("confirm", {24'h0, dev.last_cmd}, i[0] ? 32'h15 : 32'h10);
            run(8'h60, 8'hD1, 8'h0C, 3, r | 24'h40, 7'h00);
            run(8'h60, 8'hD0, 8'h0C, 3, r | 24'h40, 7'h02);
            run(8'h60, 8'hD0, 8'h0C, 3, r, 7'h00);
            run(8'h80, 8'h11, 8'h0C, 3, r, 7'h00);
            run(8'h80, 8'h10, 8'h0C, 3, r ^ 24'h41, 7'h04);
            run(8'h80, 8'h10, 8'h0C, 3, r ^ 24'h40, 7'h00);
        end
        // enable bit set, coverage option picked at random
        p1 = 8'h01 | (8'($urandom) & 8'h02);
        apb(1, OFS_COUNT, 32'h1);
        apb(1, OFS_DATA, {24'h0, p1});
        run(8'hEF, 8'h00, 8'h08, 1, 24'hB0, 7'h00);
        chk("scramble on", {31'h0, s[SB_SCR_ON]}, 32'h1);
        apb(1, OFS_COUNT, 32'h1);
        run(8'hEE, 8'h00, 8'h30, 1, 24'hB0, 7'h00);
        apb(0, OFS_RX, 32'h0);
        chk("feature", {24'h0, s[7:0]}, {24'h0, p1});
        run(8'h70, 8'h00, 8'h20, 0, 24'h0, 7'h00);
        apb(0, OFS_RX, 32'h0);
        chk("status byte", {24'h0, s[7:0]}, 32'hE0);
        run(8'h80, 8'h10, 8'h4C, 3, r, 7'h00);
        run(8'h80, 8'h10, 8'h4C, 3, r, 7'h20);
        chk("write protect", {31'h0, wp_n}, 32'h1);
        chk("bus released", {31'h0, io_oe}, 32'h0);
        close_out;
    end
endmodule
